// ---- src/iopm_defs.svh ----
// Constants for the keypad and I/O pin-function block
`ifndef IOPM_DEFS_SVH
`define IOPM_DEFS_SVH
// ----------------------------------------------------------------
// Pin counts and positions (bits 0..7 columns, 8..19 rows)
// ----------------------------------------------------------------
`define IOPM_NPIN        20
`define IOPM_NCOL        8
`define IOPM_NROW        12
`define IOPM_ROW8        16
`define IOPM_ROW9        17
`define IOPM_ROW10       18
`define IOPM_ROW11       19
// ----------------------------------------------------------------
// Serial slave address and register offsets
// ----------------------------------------------------------------
`define IOPM_SLAVE_ADDR  7'h44
`define IOPM_REG_SEL     8'h10
`define IOPM_REG_DIR     8'h13
`define IOPM_REG_OUT     8'h16
`define IOPM_REG_IN      8'h19
`define IOPM_REG_POL     8'h1c
`define IOPM_REG_STAT    8'h1f
`define IOPM_REG_IEN     8'h22
`define IOPM_REG_PULL    8'h25
`define IOPM_REG_ALT     8'h28
`define IOPM_REG_RSTCLR  8'h84
`define IOPM_GRP_LEN     8'h03
`define IOPM_POR_CLR_VAL 8'h01
// ----------------------------------------------------------------
// Field positions of the alternate-function register
// ----------------------------------------------------------------
`define IOPM_ALT_R8_LSB  0
`define IOPM_ALT_R9      2
`define IOPM_ALT_R10     3
`define IOPM_ALT_R11     4
`define IOPM_ALT_CLKOUT  2'h1
`define IOPM_ALT_PWM_CHANNEL_2    2'h2
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define IOPM_PULL_RST    20'h7_ffff
`define IOPM_ZERO20      20'h0_0000
`define IOPM_ZERO8       8'h00
`endif

// ---- src/iopm_i2c_slave.sv ----
// Serial (two-wire) register slave with auto-incrementing pointer
`timescale 1ns/1ns
`include "iopm_defs.svh"
module iopm_i2c_slave
    import iopm_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = `IOPM_SLAVE_ADDR
) (
    // Clock and reset
    input  wire logic            clk_i,
    input  wire logic            rst_n_i,
    // Serial pins
    input  wire logic            scl_i,
    input  wire logic            sda_i,
    output logic                 sda_o,
    output logic                 sda_oe_o,
    // Register side
    output iopm_pkg::iopm_wr_s   wr_o,
    output logic [7:0]           rd_addr_o,
    input  wire logic [7:0]      rd_data_i
);
    import iopm_pkg::*;

    logic [2:0]   scl_s_q, sda_s_q;
    logic         scl_rise, scl_fall, start_c, stop_c;
    iopm_i2c_st_e st_q;
    logic [7:0]   sh_q;
    logic [3:0]   cnt_q;
    logic         rw_q, first_q;

    // ------------------------------------------------------------
    // Synchronisers; only stages 1 and 2 are looked at by logic
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
        end else begin
            scl_s_q <= {scl_s_q[1:0], scl_i};
            sda_s_q <= {sda_s_q[1:0], sda_i};
        end
    end

    // Bus events seen on the synchronised lines
    assign scl_rise = scl_s_q[1] & ~scl_s_q[2];
    assign scl_fall = ~scl_s_q[1] & scl_s_q[2];
    assign start_c  = scl_s_q[1] & ~sda_s_q[1] & sda_s_q[2];
    assign stop_c   = scl_s_q[1] & sda_s_q[1] & ~sda_s_q[2];

    // Line only ever pulled low; the data output stays at zero
    always_ff @(posedge clk_i) begin
        sda_o <= 1'b0;
    end

    // ------------------------------------------------------------
    // Byte engine: bits are taken on rising SCL, driven on falling
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_q      <= ST_IDLE;
            sh_q      <= `IOPM_ZERO8;
            cnt_q     <= 4'h0;
            rw_q      <= 1'b0;
            first_q   <= 1'b0;
            sda_oe_o  <= 1'b0;
            rd_addr_o <= `IOPM_ZERO8;
            wr_o      <= '0;
        end else begin
            wr_o.vld <= 1'b0;
            if (start_c) begin
                st_q     <= ST_ADDR;
                cnt_q    <= 4'h0;
                sda_oe_o <= 1'b0;
            end else if (stop_c) begin
                st_q     <= ST_IDLE;
                sda_oe_o <= 1'b0;
            end else if (scl_rise) begin
                case (st_q)
                    ST_ADDR, ST_RX: begin
                        sh_q  <= {sh_q[6:0], sda_s_q[1]};
                        cnt_q <= cnt_q + 4'h1;
                    end
                    ST_TX: cnt_q <= cnt_q + 4'h1;
                    ST_TACK: if (sda_s_q[1]) st_q <= ST_IDLE; // Master refused more data
                    default: ;
                endcase
            end else if (scl_fall) begin
                case (st_q)
                    ST_ADDR: if (cnt_q == 4'h8) begin
                        if (sh_q[7:1] == SLAVE_ADDR) begin
                            st_q     <= ST_AACK;
                            rw_q     <= sh_q[0];
                            sda_oe_o <= 1'b1;
                        end else begin
                            st_q <= ST_IDLE;
                        end
                    end
                    ST_AACK, ST_TACK: begin
                        if (rw_q) begin
                            st_q      <= ST_TX;
                            sda_oe_o  <= ~rd_data_i[7];
                            sh_q      <= {rd_data_i[6:0], 1'b0};
                            rd_addr_o <= rd_addr_o + 8'h01;
                        end else begin
                            st_q     <= ST_RX;
                            sda_oe_o <= 1'b0;
                            first_q  <= 1'b1;
                        end
                        cnt_q <= 4'h0;
                    end
                    ST_RX: if (cnt_q == 4'h8) begin
                        st_q     <= ST_RACK;
                        sda_oe_o <= 1'b1;
                        first_q  <= 1'b0;
                        if (first_q) begin
                            rd_addr_o <= sh_q; // First byte sets the register pointer
                        end else begin
                            wr_o      <= '{vld: 1'b1, addr: rd_addr_o, data: sh_q};
                            rd_addr_o <= rd_addr_o + 8'h01;
                        end
                    end
                    ST_RACK: begin
                        st_q     <= ST_RX;
                        sda_oe_o <= 1'b0;
                        cnt_q    <= 4'h0;
                    end
                    ST_TX: begin
                        if (cnt_q == 4'h8) begin
                            st_q     <= ST_TACK;
                            sda_oe_o <= 1'b0;
                        end else begin
                            sda_oe_o <= ~sh_q[7];
                            sh_q     <= {sh_q[6:0], 1'b0};
                        end
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule // iopm_i2c_slave

// ---- src/iopm_pin_mux.sv ----
// Pin-function, reset-state and edge-interrupt logic of the keypad pins
// Functional notes
// - Every column pin and rows 0 to 10 are a keypad line or a host GPIO unless rows 8 to 10 take an alternate function; row 11 never is.
// - GPIO only takes a pin when no PWM or other alternate function holds it.
// - Input pins flag edges into status and raise the request; edge polarity selectable.
// - After reset all column pins are push-pull with pull-up enabled.
// - After reset rows 0 to 10 are push-pull with pull-down enabled.
// - After reset row 11 is open-drain, no pull, driving the request low.
// - Serial clock and data pins are open-drain with no pull after reset.
// - A power-on flag forces the request line low after every reset.
// - Writing 0x01 to offset 0x84 clears the power-on flag, releasing the line.
`timescale 1ns/1ns
`include "iopm_defs.svh"
module iopm_pin_mux
    import iopm_pkg::*;
#(
    parameter int          NPIN       = `IOPM_NPIN,
    parameter logic [6:0]  SLAVE_ADDR = `IOPM_SLAVE_ADDR
) (
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_n_i,
    // Serial register port
    input  wire logic               scl_i,
    output logic                    scl_o,
    output logic                    scl_oe_o,
    input  wire logic               sda_i,
    output logic                    sda_o,
    output logic                    sda_oe_o,
    // Keypad pins
    input  wire logic [NPIN-1:0]    pin_i,
    output iopm_pkg::iopm_pad_s     pad_o,
    // Keypad scanner and PWM sources
    input  wire logic [NPIN-1:0]    kp_out_i,
    input  wire logic [NPIN-1:0]    kp_oe_i,
    output logic [NPIN-1:0]         kp_in_o,
    input  wire logic [2:0]         pwm_i,
    input  wire logic               clk_out_i
);
    import iopm_pkg::*;

    iopm_wr_s        wr;
    logic [7:0]      rd_addr, rd_data;
    logic [NPIN-1:0] sel_q, dir_q, dout_q, pol_q, ien_q, pull_q, stat_q;
    logic [7:0]      alt_q;
    logic            por_q;
    logic [NPIN-1:0] in_s1_q, in_s3_q, hit, clr;
    logic [NPIN-1:0] alt_en, alt_val, alt_oe, out_d, oe_d, od_d;
    logic            irq_act, por_clr;

    // Pull reset pattern, split into column and row parts at reset
    localparam logic [NPIN-1:0] PULL_RST = `IOPM_PULL_RST;

    // ------------------------------------------------------------
    // Serial slave
    // ------------------------------------------------------------
    iopm_i2c_slave #(
        .SLAVE_ADDR (SLAVE_ADDR)
    ) u_slave (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .scl_i     (scl_i),
        .sda_i     (sda_i),
        .sda_o     (sda_o),
        .sda_oe_o  (sda_oe_o),
        .wr_o      (wr),
        .rd_addr_o (rd_addr),
        .rd_data_i (rd_data)
    );

    // Clock line is never driven: clock stretching is not used
    always_ff @(posedge clk_i) begin
        scl_o    <= 1'b0;
        scl_oe_o <= 1'b0;
    end

    // True when address a falls in the three-byte group at base b
    function automatic logic in_grp(input logic [7:0] a, input logic [7:0] b);
        return (a >= b) && (a < b + `IOPM_GRP_LEN);
    endfunction

    // Byte write into a pin vector
    function automatic logic [NPIN-1:0] wbyte(input logic [NPIN-1:0] v, input logic [7:0] a,
                                              input logic [7:0] b, input logic [7:0] d);
        logic [23:0] t;
        t = {{(24-NPIN){1'b0}}, v};
        t[8*(a-b) +: 8] = d;
        return t[NPIN-1:0];
    endfunction

    // Byte read from a pin vector; bits above the pins read zero
    function automatic logic [7:0] rbyte(input logic [NPIN-1:0] v, input logic [7:0] a,
                                         input logic [7:0] b);
        logic [23:0] t;
        t = {{(24-NPIN){1'b0}}, v};
        return t[8*(a-b) +: 8];
    endfunction

    // ------------------------------------------------------------
    // Configuration registers; all return to defaults on reset
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sel_q  <= `IOPM_ZERO20;
            dir_q  <= `IOPM_ZERO20;
            dout_q <= `IOPM_ZERO20;
            pol_q  <= `IOPM_ZERO20;
            ien_q  <= `IOPM_ZERO20;
            pull_q <= `IOPM_PULL_RST;
            alt_q  <= `IOPM_ZERO8;
        end else if (wr.vld) begin
            if (in_grp(wr.addr, `IOPM_REG_SEL))  sel_q  <= wbyte(sel_q,  wr.addr, `IOPM_REG_SEL,  wr.data);
            if (in_grp(wr.addr, `IOPM_REG_DIR))  dir_q  <= wbyte(dir_q,  wr.addr, `IOPM_REG_DIR,  wr.data);
            if (in_grp(wr.addr, `IOPM_REG_OUT))  dout_q <= wbyte(dout_q, wr.addr, `IOPM_REG_OUT,  wr.data);
            if (in_grp(wr.addr, `IOPM_REG_POL))  pol_q  <= wbyte(pol_q,  wr.addr, `IOPM_REG_POL,  wr.data);
            if (in_grp(wr.addr, `IOPM_REG_IEN))  ien_q  <= wbyte(ien_q,  wr.addr, `IOPM_REG_IEN,  wr.data);
            if (in_grp(wr.addr, `IOPM_REG_PULL)) pull_q <= wbyte(pull_q, wr.addr, `IOPM_REG_PULL, wr.data);
            if (wr.addr == `IOPM_REG_ALT)        alt_q  <= wr.data;
        end
    end

    // ------------------------------------------------------------
    // Input synchronisers and edge detection
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            in_s1_q <= `IOPM_ZERO20;
            kp_in_o <= `IOPM_ZERO20;
            in_s3_q <= `IOPM_ZERO20;
        end else begin
            in_s1_q <= pin_i;
            kp_in_o <= in_s1_q;
            in_s3_q <= kp_in_o;
        end
    end

    // Only pins not driven by the block count as inputs
    assign hit = ~pad_o.oe & ((pol_q & kp_in_o & ~in_s3_q) | (~pol_q & ~kp_in_o & in_s3_q));
    assign clr = (wr.vld && in_grp(wr.addr, `IOPM_REG_STAT)) ?
                 wbyte(`IOPM_ZERO20, wr.addr, `IOPM_REG_STAT, wr.data) : `IOPM_ZERO20;

    // Sticky edge status, write one to clear; a new edge beats the clear
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            stat_q <= `IOPM_ZERO20;
        end else begin
            stat_q <= (stat_q & ~clr) | hit;
        end
    end

    // ------------------------------------------------------------
    // Power-on request flag
    // ------------------------------------------------------------
    assign por_clr = wr.vld && (wr.addr == `IOPM_REG_RSTCLR) && (wr.data == `IOPM_POR_CLR_VAL);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            por_q <= 1'b1;
        end else if (por_clr) begin
            por_q <= 1'b0;
        end
    end

    assign irq_act = por_q | (|(stat_q & ien_q));

    // ------------------------------------------------------------
    // Register read mux; write-only and unmapped offsets read zero
    // ------------------------------------------------------------
    always_comb begin
        rd_data = `IOPM_ZERO8;
        if (in_grp(rd_addr, `IOPM_REG_SEL))  rd_data = rbyte(sel_q,   rd_addr, `IOPM_REG_SEL);
        if (in_grp(rd_addr, `IOPM_REG_DIR))  rd_data = rbyte(dir_q,   rd_addr, `IOPM_REG_DIR);
        if (in_grp(rd_addr, `IOPM_REG_OUT))  rd_data = rbyte(dout_q,  rd_addr, `IOPM_REG_OUT);
        if (in_grp(rd_addr, `IOPM_REG_IN))   rd_data = rbyte(kp_in_o, rd_addr, `IOPM_REG_IN);
        if (in_grp(rd_addr, `IOPM_REG_POL))  rd_data = rbyte(pol_q,   rd_addr, `IOPM_REG_POL);
        if (in_grp(rd_addr, `IOPM_REG_STAT)) rd_data = rbyte(stat_q,  rd_addr, `IOPM_REG_STAT);
        if (in_grp(rd_addr, `IOPM_REG_IEN))  rd_data = rbyte(ien_q,   rd_addr, `IOPM_REG_IEN);
        if (in_grp(rd_addr, `IOPM_REG_PULL)) rd_data = rbyte(pull_q,  rd_addr, `IOPM_REG_PULL);
        if (rd_addr == `IOPM_REG_ALT)        rd_data = alt_q;
    end

    // ------------------------------------------------------------
    // Alternate functions of rows 8 to 11
    // ------------------------------------------------------------
    always_comb begin
        alt_en  = `IOPM_ZERO20;
        alt_val = `IOPM_ZERO20;
        alt_oe  = `IOPM_ZERO20;
        od_d    = `IOPM_ZERO20;
        alt_en[`IOPM_ROW8]  = (alt_q[`IOPM_ALT_R8_LSB +: 2] != 2'h0);
        alt_val[`IOPM_ROW8] = (alt_q[`IOPM_ALT_R8_LSB +: 2] == `IOPM_ALT_CLKOUT) ? clk_out_i : pwm_i[2];
        alt_en[`IOPM_ROW9]  = alt_q[`IOPM_ALT_R9];
        alt_val[`IOPM_ROW9] = pwm_i[1];
        alt_en[`IOPM_ROW10] = alt_q[`IOPM_ALT_R10];
        alt_val[`IOPM_ROW10]= pwm_i[0];
        alt_oe              = alt_en;
        // Row 11 is always taken: request line unless PWM_CHANNEL_2 is chosen
        alt_en[`IOPM_ROW11] = 1'b1;
        alt_val[`IOPM_ROW11]= alt_q[`IOPM_ALT_R11] & pwm_i[2];
        alt_oe[`IOPM_ROW11] = alt_q[`IOPM_ALT_R11] | irq_act;
        od_d[`IOPM_ROW11]   = ~alt_q[`IOPM_ALT_R11];
    end

    // Per-pin function select: alternate, then GPIO, then keypad scanner
    for (genvar k = 0; k < NPIN; k++) begin : g_pin
        assign out_d[k] = alt_en[k] ? alt_val[k] : (sel_q[k] ? dout_q[k] : kp_out_i[k]);
        assign oe_d[k]  = alt_en[k] ? alt_oe[k]  : (sel_q[k] ? dir_q[k]  : kp_oe_i[k]);
    end

    // Registered pad controls; reset puts every pin in its defined state
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pad_o.out <= `IOPM_ZERO20;
            pad_o.oe  <= `IOPM_ZERO20;
            pad_o.oe[`IOPM_ROW11] <= 1'b1;
            pad_o.pu  <= PULL_RST[`IOPM_NCOL-1:0];
            pad_o.pd  <= PULL_RST[NPIN-1:`IOPM_NCOL];
            pad_o.od  <= `IOPM_ZERO20;
            pad_o.od[`IOPM_ROW11] <= 1'b1;
        end else begin
            pad_o.out <= out_d;
            pad_o.oe  <= oe_d;
            pad_o.pu  <= pull_q[`IOPM_NCOL-1:0];
            pad_o.pd  <= pull_q[NPIN-1:`IOPM_NCOL] & ~od_d[NPIN-1:`IOPM_NCOL];
            pad_o.od  <= od_d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_por_release;
        por_clr ##1 !por_q;
    endsequence

    chk_col_reset: assert property (!$past(rst_n_i) |-> pad_o.pu == 8'hff && pad_o.oe[7:0] == 8'h00)
        else $error("columns not in reset state");
    chk_row_reset: assert property (!$past(rst_n_i) |-> pad_o.pd == 12'h7ff && pad_o.od[18:0] == 19'h0_0000)
        else $error("rows not in reset state");
    chk_irq_reset: assert property (!$past(rst_n_i) |-> pad_o.oe[19] && !pad_o.out[19] && pad_o.od[19])
        else $error("request pin not driving low after reset");
    chk_serial_od: assert property (!sda_o && !scl_oe_o)
        else $error("serial pins not open drain");
    chk_por_hold: assert property (por_q && !por_clr |=> por_q ##1 (pad_o.oe[19] || alt_q[4]))
        else $error("power-on flag lost");
    chk_por_clear: assert property (por_clr |-> s_por_release)
        else $error("power-on flag not cleared");
    chk_edge_flag: assert property (|hit |=> (stat_q & $past(hit)) == $past(hit))
        else $error("edge not recorded");
    chk_alt_pwm: assert property (alt_q[2] |=> pad_o.out[17] == $past(pwm_i[1]) && pad_o.oe[17])
        else $error("row 9 not carrying PWM_CHANNEL_1");
    chk_gpio_excl: assert property (sel_q[16] && alt_q[1:0] == 2'h2 |=> pad_o.out[16] == $past(pwm_i[2]))
        else $error("GPIO took a PWM pin");
    chk_gpio_drive: assert property (!alt_en[0] |=> pad_o.oe[0] == $past(sel_q[0] ? dir_q[0] : kp_oe_i[0]))
        else $error("pin 0 function select wrong");
    chk_cfg_reset: assert property (!$past(rst_n_i) |-> sel_q == 20'h0_0000 && alt_q == 8'h00 && por_q)
        else $error("configuration kept over reset");
endmodule // iopm_pin_mux

// ---- src/iopm_pkg.sv ----
// Types shared by the pin-function block and its serial slave
package iopm_pkg;
`include "iopm_defs.svh"
    // Serial slave states
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_AACK, ST_RX, ST_RACK, ST_TX, ST_TACK} iopm_i2c_st_e;
    // One register write from the serial slave
    typedef struct packed {
        logic       vld;
        logic [7:0] addr;
        logic [7:0] data;
    } iopm_wr_s;
    // Pad controls for all keypad pins
    typedef struct packed {
        logic [`IOPM_NPIN-1:0] out;
        logic [`IOPM_NPIN-1:0] oe;
        logic [`IOPM_NCOL-1:0] pu;
        logic [`IOPM_NROW-1:0] pd;
        logic [`IOPM_NPIN-1:0] od;
    } iopm_pad_s;
endpackage

// ---- tb/io_pin_function_reset_state_tb_top.sv ----
// Self-checking bench for the keypad pin-function block
`timescale 1ns/1ns
module io_pin_function_reset_state_tb_top;
    import iopm_pkg::*;
    logic        clk_i, rst_n_i, h_scl, h_sda, scl_oe, sda_oe, scl_o, sda_o, clk_out;
    logic [19:0] pin, kp_out, kp_oe, kp_in;
    logic [2:0]  pwm;
    iopm_pad_s   pad;
    int          bad_count, n_compared;
    // Open-drain lines: low wins, pull-up otherwise
    wire logic   scl_w = h_scl & ~scl_oe;
    wire logic   sda_w = h_sda & ~sda_oe;
    // 25 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    iopm_pin_mux u_iopm_pin_mux (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl_w), .scl_o(scl_o),
        .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe), .pin_i(pin), .pad_o(pad),
        .kp_out_i(kp_out), .kp_oe_i(kp_oe), .kp_in_o(kp_in), .pwm_i(pwm), .clk_out_i(clk_out));
    iopm_host_model u_iopm_host_model (.clk_i(clk_i), .sda_i(sda_w), .scl_o(h_scl), .sda_o(h_sda));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check_vec(input string nm, input logic [19:0] exp, input logic [19:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Write through the host; every byte must be acknowledged
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ok;
        u_iopm_host_model.wr({`IOPM_SLAVE_ADDR, 1'b0}, a, d, ok);
        #1;
        check_vec("ack", 20'h0_0001, {19'h0, ok});
    endtask
    function automatic logic [19:0] req();
        return {19'h0, pad.oe[19]};
    endfunction
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic sc_reset_state();
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        kp_oe   <= 20'h0_0000;
        kp_out  <= 20'h0_0000;
        cyc(10);
        rst_n_i <= 1'b1;
        cyc(1);
        check_vec("pu", 20'h0_00ff, {12'h0, pad.pu});
        check_vec("pd", 20'h0_07ff, {8'h0, pad.pd});
        check_vec("oe", 20'h8_0000, pad.oe);
        check_vec("od", 20'h8_0000, pad.od);
        check_vec("out", 20'h0_0000, pad.out);
        check_vec("serial", 20'h0_0000, {16'h0, scl_o, sda_o, scl_oe, sda_oe});
    endtask
    // Keypad lines first, then GPIO takes column 0 over the scanner
    task automatic sc_keypad_gpio();
        kp_out <= 20'h0_0002;
        kp_oe  <= 20'h0_0007;
        pin    <= 20'h0_0008;
        cyc(4);
        check_vec("kp oe", 20'h8_0007, pad.oe);
        check_vec("kp out", 20'h0_0002, pad.out);
        check_vec("kp in", 20'h0_0008, kp_in);
        wr(8'h10, 8'h01);
        wr(8'h13, 8'h01);
        wr(8'h16, 8'h01);
        check_vec("gpio out", 20'h0_0003, pad.out);
        wr(8'h13, 8'h00);
        check_vec("gpio in", 20'h8_0006, pad.oe);
    endtask
    task automatic sc_por_clear();
        logic ok;
        u_iopm_host_model.wr(8'h8a, 8'h84, 8'h01, ok);
        #1;
        check_vec("foreign ack", 20'h0_0000, {19'h0, ok});
        check_vec("req held", 20'h0_0001, req());
        wr(8'h84, 8'h02);
        check_vec("req other", 20'h0_0001, req());
        wr(8'h84, 8'h01);
        check_vec("req free", 20'h0_0000, req());
    endtask
    // Rising then falling edge on input column 2
    task automatic sc_edge();
        logic [7:0] v;
        logic       ok;
        wr(8'h10, 8'h05);
        wr(8'h0f, 8'h00);
        u_iopm_host_model.rd({`IOPM_SLAVE_ADDR, 1'b1}, v, ok);
        #1;
        check_vec("sel rd", 20'h0_0005, {12'h0, v});
        check_vec("rd ack", 20'h0_0001, {19'h0, ok});
        wr(8'h1c, 8'h04);
        wr(8'h22, 8'h04);
        pin <= 20'h0_000c;
        cyc(6);
        check_vec("rise req", 20'h0_0001, req());
        wr(8'h1f, 8'h04);
        check_vec("rise clr", 20'h0_0000, req());
        wr(8'h1c, 8'h00);
        pin <= 20'h0_0008;
        cyc(6);
        check_vec("fall req", 20'h0_0001, req());
        wr(8'h1f, 8'h04);
        check_vec("fall clr", 20'h0_0000, req());
    endtask
    task automatic sc_alt();
        pwm     <= 3'b110;
        clk_out <= 1'b1;
        wr(8'h28, 8'h1d);
        check_vec("alt out", 20'hb_0000, pad.out & 20'hf_0000);
        check_vec("alt oe", 20'hf_0000, pad.oe & 20'hf_0000);
        pwm <= 3'b100;
        wr(8'h12, 8'h01);
        wr(8'h28, 8'h02);
        check_vec("r8 out", 20'h1_0000, pad.out & 20'hf_0000);
        check_vec("r8 oe", 20'h1_0000, pad.oe & 20'hf_0000);
    endtask
    // Main sequence, with a second reset in mid-run at the end
    initial begin
        rst_n_i    = 1'b0;
        pin        = 20'h0_0000;
        kp_out     = 20'h0_0000;
        kp_oe      = 20'h0_0000;
        pwm        = 3'b000;
        clk_out    = 1'b0;
        bad_count  = 0;
        n_compared = 0;
        sc_reset_state();
        sc_keypad_gpio();
        sc_por_clear();
        sc_edge();
        sc_alt();
        sc_reset_state();
        tally_and_finish();
    end
endmodule // io_pin_function_reset_state_tb_top

// ---- tb/iopm_host_model.sv ----
// Behavioural serial-bus host that writes device registers
`timescale 1ns/1ns
module iopm_host_model (
    // Clock and bus
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    // Bus idles released, both lines high through the pull-ups
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // Six clocks per half period keeps well above the slave's minimum of four
    task automatic hold();
        repeat (6) @(posedge clk_i);
    endtask
    // Data moves one edge after the clock fall so it never looks like START or STOP
    task automatic bit_x(input logic b, output logic s);
        @(posedge clk_i);
        sda_o <= b;
        hold();
        scl_o <= 1'b1;
        hold();
        s = sda_i;
        scl_o <= 1'b0;
    endtask
    // Byte, most significant bit first, then the acknowledge slot
    task automatic byte_x(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(v[i], s);
        bit_x(1'b1, s);
        ack = ~s;
    endtask
    // START, device byte, offset, data, STOP
    task automatic wr(input logic [7:0] dev, input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic k0, k1, k2;
        sda_o <= 1'b0;
        hold();
        scl_o <= 1'b0;
        byte_x(dev, k0);
        byte_x(a, k1);
        byte_x(d, k2);
        @(posedge clk_i);
        sda_o <= 1'b0;
        hold();
        scl_o <= 1'b1;
        hold();
        sda_o <= 1'b1;
        hold();
        ok = k0 & k1 & k2;
    endtask
    // START, device byte with read bit, one byte in, NACK, STOP
    task automatic rd(input logic [7:0] dev, output logic [7:0] v, output logic ok);
        logic s;
        sda_o <= 1'b0;
        hold();
        scl_o <= 1'b0;
        byte_x(dev, ok);
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, s);
            v[i] = s;
        end
        bit_x(1'b1, s);
        @(posedge clk_i);
        sda_o <= 1'b0;
        hold();
        scl_o <= 1'b1;
        hold();
        sda_o <= 1'b1;
        hold();
    endtask
endmodule // iopm_host_model
